// ---- rtl/power_mode_clock_sequencer_defines.vh ----
`ifndef POWER_MODE_CLOCK_SEQUENCER_DEFINES_VH
`define POWER_MODE_CLOCK_SEQUENCER_DEFINES_VH

// register byte offsets
`define OFS_MODE_CTRL      8'h00
`define OFS_CLOCK_EXT      8'h04
`define OFS_WAKE_CFG       8'h08
`define OFS_STATUS         8'h0C

// mode control fields
`define MODE_LSB           0
`define MODE_MSB           1
`define INT_DIS_BIT        2
`define MSEL_LSB           3
`define MSEL_MSB           5
`define MODE_CTRL_RESET    6'h00

// mode codes
`define MODE_IDLE          2'h0
`define MODE_VOICE_DATA    2'h1
`define MODE_DATA_ONLY     2'h2
`define MODE_POWER_DOWN    2'h3

// clock extension fields
`define XSEL_LSB           0
`define XSEL_MSB           2
`define PD_EN_BIT          5
`define CLOCK_EXT_RESET    6'h00
`define XSEL_STOP          3'h4

// wake configuration fields
`define HOOK_IE_BIT        0
`define F7_IE_BIT          1
`define IOM_IE_BIT         2
`define LINE_RX_EN_BIT     3
`define IOM_EN_BIT         4
`define IOM_MASTER_BIT     5
`define WAKE_CFG_RESET     6'h00

// timing counts in master clock cycles
`define PD_COUNTDOWN       250
`define WAKE_MCLK_CYCLES   2

`endif

// ---- rtl/power_mode_clock_sequencer.v ----
// What this block does
// - master clock divided from crystal, seven rates
// - four power modes from mode field
// - code 11 without enable means Idle
// - voice and data mode enables audio, link controller, crossbar and port
// - data only mode drops audio processor
// - Idle after reset or by programming
// - Idle keeps clock, host, line, hookswitch
// - Idle disables port; serial pins until crossbar or IOM master
// - entering Idle clears link controller status
// - power-down stops clocks, keeps wake detection
// - power-down refused unless enable bit set
// - countdown 250 cycles, then hold clocks high
// - interrupt during countdown cancels power-down
// - line not in F3 keeps oscillator running
// - reset leaves power-down into Idle
// - host write strobe wakes, no data transferred
// - hookswitch change wakes when enabled
// - line F7 wakes when interrupts enabled
// - line noise runs oscillator, no wake
// - IOM master wakes on serial input low
// - IOM slave wakes on serial clock high
// - wake restores rate; reset gives 6.144
// - two master clocks before interrupt asserted
`include "power_mode_clock_sequencer_defines.vh"
`timescale 1ns/10ps
`default_nettype none

module power_mode_clock_sequencer
#(
  parameter integer PD_COUNT   = `PD_COUNTDOWN,
  parameter integer WAKE_COUNT = `WAKE_MCLK_CYCLES
)
(
  input  wire        i_ref_clk,
  input  wire        i_reset,
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [7:0]  i_paddr,
  input  wire [31:0] i_pwdata,
  output reg  [31:0] o_prdata,
  output reg         o_pready,
  output reg         o_pslverr,
  input  wire        i_crystal_in,
  output reg         o_crystal_out,
  output reg         o_master_clk,
  input  wire        i_irq_pending,
  output reg         o_int_n,
  input  wire        i_host_cs_n,
  input  wire        i_host_wr_n,
  output reg         o_host_write_block,
  input  wire        i_hookswitch_input,
  input  wire        i_line_f3,
  input  wire        i_line_f7,
  input  wire        i_line_osc_req,
  input  wire        i_serial_in_pin,
  input  wire        i_serial_clk_in,
  input  wire        i_crossbar_conn,
  output reg         o_audio_en,
  output reg         o_link_ctrl_en,
  output reg         o_crossbar_en,
  output reg         o_periph_en,
  output reg         o_periph_act_irq_en,
  output reg         o_line_en,
  output reg         o_host_if_en,
  output reg         o_link_ctrl_clear,
  output reg         o_serial_frame_sync_oe_n,
  output reg         o_serial_clk_oe_n
);

  localparam [3:0] ST_RUN   = 4'b0001;
  localparam [3:0] ST_COUNT = 4'b0010;
  localparam [3:0] ST_DOWN  = 4'b0100;
  localparam [3:0] ST_WAKE  = 4'b1000;
  localparam integer PD_LAST   = PD_COUNT - 1;
  localparam integer WAKE_LAST = WAKE_COUNT - 1;

  reg  [5:0] mode_ctrl;
  reg  [5:0] clock_ext;
  reg  [5:0] wake_cfg;
  reg  [3:0] state;
  reg  [3:0] next_state;
  reg  [8:0] cyc_cnt;
  reg  [5:0] period;
  reg  [5:0] sel_period;
  reg  [5:0] div_cnt;
  reg        stopped;
  reg        xtal_q;
  reg        hsw_q;
  reg        f7_q;
  reg        crossbar_made;
  reg  [1:0] mode_q;
  reg        next_mclk;
  reg  [31:0] rd_val;
  reg        rd_hit;

  wire [1:0] mode     = mode_ctrl[`MODE_MSB:`MODE_LSB];
  wire       int_dis  = mode_ctrl[`INT_DIS_BIT];
  wire [2:0] msel     = mode_ctrl[`MSEL_MSB:`MSEL_LSB];
  wire [2:0] xsel     = clock_ext[`XSEL_MSB:`XSEL_LSB];
  wire       pd_en    = clock_ext[`PD_EN_BIT];
  wire       st_run   = state[0];
  wire       st_count = state[1];
  wire       st_down  = state[2];
  wire       st_wake  = state[3];
  wire       line_rx  = wake_cfg[`LINE_RX_EN_BIT];
  wire       iom_en   = wake_cfg[`IOM_EN_BIT];
  wire       iom_mst  = wake_cfg[`IOM_MASTER_BIT];
  wire       irq_on   = i_irq_pending & ~int_dis;

  wire       setup    = i_psel & ~i_penable;
  wire       wr_done  = i_psel & i_penable & o_pready & i_pwrite;

  // oscillator runs unless powered down with a quiet line
  // oscillator stop
  wire osc_run = ~st_down | (line_rx & ~i_line_f3) | i_line_osc_req;
  wire xtal_rise = i_crystal_in & ~xtal_q & osc_run;
  wire mclk_rise = next_mclk & ~o_master_clk;
  wire div_wrap = stopped | (div_cnt >= period - 6'd1);

  wire wake_host = ~i_host_cs_n & ~i_host_wr_n;
  wire wake_hook = (i_hookswitch_input != hsw_q) & wake_cfg[`HOOK_IE_BIT];
  wire wake_f7 = line_rx & i_line_f7 & ~f7_q & ~int_dis & wake_cfg[`F7_IE_BIT];
  wire wake_iom_m = iom_en & iom_mst & ~i_serial_in_pin & ~int_dis & wake_cfg[`IOM_IE_BIT];
  wire wake_iom_s = iom_en & ~iom_mst & i_serial_clk_in & ~int_dis & wake_cfg[`IOM_IE_BIT];
  wire wake_any = wake_host | wake_hook | wake_f7 | wake_iom_m | wake_iom_s;

  always @*
  begin
    sel_period = 6'd2;
    case (xsel)
      3'h1:    sel_period = 6'd8;
      3'h2:    sel_period = 6'd16;
      3'h3:    sel_period = 6'd32;
      default:
      begin
        case (msel)
          3'h1:    sel_period = 6'd1;
          3'h2:    sel_period = 6'd4;
          3'h4:    sel_period = 6'd3;
          default: sel_period = 6'd2;
        endcase
      end
    endcase
  end

  always @*
  begin
    if (stopped || st_down)
      next_mclk = 1'b1;
    else if (period == 6'd1)
      next_mclk = i_crystal_in & osc_run;
    else
      next_mclk = (div_cnt < (period - (period >> 1)));
  end

  always @*
  begin
    next_state = state;
    case (state)
      ST_RUN:
        if (mode == `MODE_POWER_DOWN)
          next_state = ST_COUNT;
      ST_COUNT:
        if (irq_on || mode != `MODE_POWER_DOWN)
          next_state = ST_RUN;
        else if (mclk_rise && cyc_cnt == PD_LAST[8:0])
          next_state = ST_DOWN;
      ST_DOWN:
        if (wake_any)
          next_state = ST_WAKE;
      ST_WAKE:
        if (mclk_rise && cyc_cnt == WAKE_LAST[8:0])
          next_state = ST_RUN;
      default:
        next_state = ST_RUN;
    endcase
  end

  always @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      state   <= ST_RUN;
      cyc_cnt <= 9'd0;
    end
    else
    begin
      state <= next_state;
      if (next_state != state)
        cyc_cnt <= 9'd0;
      else if ((st_count || st_wake) && mclk_rise)
        cyc_cnt <= cyc_cnt + 9'd1;
    end
  end

  // changes of rate or stop only land at a period boundary, so no short pulse
  always @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      xtal_q       <= 1'b0;
      div_cnt      <= 6'd0;
      period       <= 6'd2;
      stopped      <= 1'b0;
      o_master_clk <= 1'b1;
      o_crystal_out <= 1'b1;
    end
    else
    begin
      xtal_q <= i_crystal_in;
      if (st_down)
        stopped <= 1'b1;
      if (xtal_rise)
      begin
        if (div_wrap)
        begin
          div_cnt <= 6'd0;
          period  <= sel_period;
          stopped <= st_down | (xsel == `XSEL_STOP);
        end
        else
          div_cnt <= div_cnt + 6'd1;
      end
      o_master_clk <= next_mclk;
      o_crystal_out <= osc_run ? ~i_crystal_in : 1'b1;
    end
  end

  // register writes
  always @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      mode_ctrl <= `MODE_CTRL_RESET;
      clock_ext <= `CLOCK_EXT_RESET;
      wake_cfg  <= `WAKE_CFG_RESET;
    end
    else
    begin
      if (wr_done && i_paddr == `OFS_MODE_CTRL)
      begin
        mode_ctrl <= i_pwdata[5:0];
        if (i_pwdata[1:0] == `MODE_POWER_DOWN && !pd_en)
          mode_ctrl[`MODE_MSB:`MODE_LSB] <= `MODE_IDLE;
      end
      else if (st_count && irq_on)
        mode_ctrl[`MODE_MSB:`MODE_LSB] <= `MODE_IDLE;
      else if (st_down && wake_any)
        mode_ctrl[`MODE_MSB:`MODE_LSB] <= `MODE_IDLE;
      if (wr_done && i_paddr == `OFS_CLOCK_EXT)
        clock_ext <= i_pwdata[5:0];
      if (wr_done && i_paddr == `OFS_WAKE_CFG)
        wake_cfg <= i_pwdata[5:0];
    end
  end

  always @*
  begin
    rd_val = 32'h00000000;
    rd_hit = 1'b1;
    case (i_paddr)
      `OFS_MODE_CTRL: rd_val[5:0] = mode_ctrl;
      `OFS_CLOCK_EXT: rd_val[5:0] = clock_ext;
      `OFS_WAKE_CFG:  rd_val[5:0] = wake_cfg;
      `OFS_STATUS:    rd_val[7:0] = {i_line_f3, stopped, osc_run, 1'b0, state};
      default:        rd_hit = 1'b0;
    endcase
  end

  // no wait state: read data latched in the setup cycle
  always @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h00000000;
    end
    else
    begin
      o_pready  <= setup;
      o_pslverr <= setup & ~rd_hit;
      if (setup)
        o_prdata <= (i_pwrite || !rd_hit) ? 32'h00000000 : rd_val;
    end
  end

  // block gating and pins
  always @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      hsw_q                    <= 1'b0;
      f7_q                     <= 1'b0;
      crossbar_made            <= 1'b0;
      mode_q                   <= `MODE_IDLE;
      o_int_n                  <= 1'b1;
      o_host_write_block       <= 1'b0;
      o_audio_en               <= 1'b0;
      o_link_ctrl_en           <= 1'b0;
      o_crossbar_en            <= 1'b0;
      o_periph_en              <= 1'b0;
      o_periph_act_irq_en      <= 1'b0;
      o_line_en                <= 1'b0;
      o_host_if_en             <= 1'b0;
      o_link_ctrl_clear        <= 1'b0;
      o_serial_frame_sync_oe_n <= 1'b1;
      o_serial_clk_oe_n        <= 1'b1;
    end
    else
    begin
      hsw_q <= i_hookswitch_input;
      f7_q  <= i_line_f7;
      crossbar_made <= crossbar_made | i_crossbar_conn;
      o_int_n <= ~(irq_on & ~st_down & ~st_wake);
      if (st_down)
        o_host_write_block <= 1'b1;
      else if (i_host_wr_n)
        o_host_write_block <= 1'b0;
      // all blocks in voice and data
      o_audio_en     <= st_run & (mode == `MODE_VOICE_DATA);
      o_link_ctrl_en <= st_run & (mode == `MODE_VOICE_DATA || mode == `MODE_DATA_ONLY);
      o_crossbar_en  <= st_run & (mode == `MODE_VOICE_DATA || mode == `MODE_DATA_ONLY);
      // port off in idle, irq kept
      o_periph_en    <= st_run & (mode == `MODE_VOICE_DATA || mode == `MODE_DATA_ONLY);
      o_periph_act_irq_en <= ~st_down & iom_en;
      o_line_en      <= line_rx;
      o_host_if_en   <= ~st_down;
      // clear link status on Idle entry
      mode_q            <= mode;
      o_link_ctrl_clear <= (mode == `MODE_IDLE) && (mode_q != `MODE_IDLE);
      o_serial_frame_sync_oe_n <= ~(crossbar_made | i_crossbar_conn | (iom_en & iom_mst));
      o_serial_clk_oe_n        <= ~(crossbar_made | i_crossbar_conn | (iom_en & iom_mst));
    end
  end

endmodule

`default_nettype wire

// ---- tb/host_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module host_model
(
  input  wire logic i_clk,
  input  wire logic i_go,
  output wire logic o_cs_n,
  output wire logic o_wr_n
);
  logic [2:0] cnt;
  initial cnt = 3'h0;
  always @(posedge i_clk)
  begin
    if (i_go)
      cnt <= 3'h4;
    else if (cnt != 3'h0)
      cnt <= cnt - 3'h1;
  end
  assign o_cs_n = (cnt == 3'h0);
  assign o_wr_n = (cnt == 3'h0);
endmodule
`default_nettype wire

// ---- tb/pmcs_chk.sv ----
`timescale 1ns/10ps
`default_nettype none
module pmcs_chk
#(
  parameter integer PD_COUNT   = 250,
  parameter integer WAKE_COUNT = 2
)
(
  input wire logic        i_ref_clk,
  input wire logic        i_reset,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_line_osc_req,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  input wire logic        o_crystal_out,
  input wire logic        o_master_clk,
  input wire logic        o_int_n,
  input wire logic        o_host_write_block,
  input wire logic        o_audio_en,
  input wire logic        o_link_ctrl_en,
  input wire logic        o_crossbar_en,
  input wire logic        o_periph_en,
  input wire logic        o_line_en,
  input wire logic        o_host_if_en,
  input wire logic        o_link_ctrl_clear,
  input wire logic        o_serial_frame_sync_oe_n,
  input wire logic        o_serial_clk_oe_n
);
  // cycles spent powered down; outputs settle well before 64
  logic [6:0] dn;
  always @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
      dn <= 7'h00;
    else if (o_host_if_en)
      dn <= 7'h00;
    else if (dn != 7'h7F)
      dn <= dn + 7'h01;
  end
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_reset);
  a_setup_ready: assert property (i_psel && !i_penable |=> o_pready)
    else $error("no ready after setup");
  a_err_zero: assert property (o_pslverr |-> o_pready && o_prdata == 32'h00000000)
    else $error("error without ready or zero data");
  a_audio_all: assert property (o_audio_en |-> o_link_ctrl_en && o_crossbar_en && o_periph_en && o_host_if_en)
    else $error("audio on without other blocks");
  a_clear_pulse: assert property (o_link_ctrl_clear |=> !o_link_ctrl_clear)
    else $error("clear pulse too long");
  a_idle_link: assert property (o_link_ctrl_clear |-> ##[0:1] !o_link_ctrl_en)
    else $error("link controller on in idle");
  a_down_int: assert property (!o_host_if_en |-> o_int_n)
    else $error("interrupt low while down");
  a_down_mclk: assert property (dn > 7'd64 |-> o_master_clk)
    else $error("master clock not held high");
  a_down_xtal: assert property (dn > 7'd64 && !o_line_en && !i_line_osc_req && !$past(i_line_osc_req)
    |-> o_crystal_out)
    else $error("crystal output not held high");
  a_wake_int: assert property ($rose(o_host_if_en) && $past(o_host_write_block) |-> o_int_n [*8])
    else $error("interrupt too soon after wake");
  a_block_down: assert property ($fell(o_host_if_en) |-> ##[0:1] o_host_write_block)
    else $error("host write not blocked when down");
  a_oe_pair: assert property (o_serial_frame_sync_oe_n == o_serial_clk_oe_n)
    else $error("serial output enables differ");
  c_wake: cover property ($rose(o_host_if_en) && $past(o_host_write_block));
  c_audio: cover property (o_audio_en);
  c_err: cover property (o_pslverr);
endmodule
bind power_mode_clock_sequencer pmcs_chk #(.PD_COUNT(PD_COUNT), .WAKE_COUNT(WAKE_COUNT)) u_chk (.*);
`default_nettype wire

// ---- tb/testbench.sv ----
`include "power_mode_clock_sequencer_defines.vh"
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic             i_ref_clk, i_reset, i_psel, i_penable, i_pwrite, i_crystal_in, i_irq_pending, go;
  logic             i_hookswitch_input, i_line_f3, i_line_f7, i_line_osc_req, i_serial_in_pin;
  logic             i_serial_clk_in, i_crossbar_conn;
  logic [7:0]       i_paddr;
  logic [31:0]      i_pwdata, rd_v;
  logic [2:0]       xc;
  wire logic [31:0] o_prdata;
  wire logic        o_pready, o_pslverr, o_crystal_out, o_master_clk, o_int_n, o_host_write_block;
  wire logic        i_host_cs_n, i_host_wr_n, o_audio_en, o_link_ctrl_en, o_crossbar_en, o_periph_en;
  wire logic        o_periph_act_irq_en, o_line_en, o_host_if_en, o_link_ctrl_clear;
  wire logic        o_serial_frame_sync_oe_n, o_serial_clk_oe_n;
  int               fail_count, n_tests, per, clr_n;
  time              t0;
  // short countdown keeps the run brief
  power_mode_clock_sequencer #(.PD_COUNT(4), .WAKE_COUNT(2)) u_dut (.*);
  host_model u_host (.i_clk(i_ref_clk), .i_go(go), .o_cs_n(i_host_cs_n), .o_wr_n(i_host_wr_n));
  initial
  begin
    i_ref_clk = 1'b0;
    forever #10 i_ref_clk = ~i_ref_clk;
  end
  // crystal of eight reference cycles
  always @(posedge i_ref_clk)
  begin
    xc <= xc + 3'h1;
    i_crystal_in <= xc[2];
    if (o_link_ctrl_clear === 1'b1) clr_n <= clr_n + 1;
  end
  always @(posedge o_master_clk)
  begin
    per <= int'(($time - t0) / 20);
    t0 <= $time;
  end
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic stall;
    fail_count++;
    report_and_stop;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic e);
    int k;
    @(posedge i_ref_clk);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_ref_clk);
    i_penable <= 1'b1;
    for (k = 0; k < 50; k++)
    begin
      @(posedge i_ref_clk);
      if (o_pready === 1'b1) break;
    end
    rd_v = o_prdata;
    e = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    if (k == 50) stall;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic e;
    apb(1'b1, a, d, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic e;
    apb(1'b0, a, 32'h0, e);
    chk(rd_v, exp);
  endtask
  task automatic wait_if(input logic v);
    int k;
    for (k = 0; k < 3000 && o_host_if_en !== v; k++) @(posedge i_ref_clk);
    if (k == 3000) stall;
  endtask
  task automatic t_reset;
    logic e;
    rd(`OFS_MODE_CTRL, 32'h0);
    rd(`OFS_CLOCK_EXT, 32'h0);
    apb(1'b0, 8'h10, 32'h0, e);
    chk(e, 1'b1);
    chk({o_audio_en, o_link_ctrl_en, o_crossbar_en, o_periph_en, o_host_if_en}, 5'h01);
    chk(o_serial_clk_oe_n, 1'b1);
    repeat (100) @(posedge i_ref_clk);
    chk(per, 16);
    $display("reset test done");
  endtask
  task automatic t_modes;
    int m;
    int c;
    for (m = 1; m < 3; m++)
    begin
      wr(`OFS_MODE_CTRL, m);
      repeat (3) @(posedge i_ref_clk);
      chk({o_audio_en, o_link_ctrl_en, o_crossbar_en, o_periph_en}, {m == 1, 3'h7});
    end
    c = clr_n;
    wr(`OFS_MODE_CTRL, 32'h0);
    repeat (3) @(posedge i_ref_clk);
    chk(clr_n - c, 1);
    chk({o_link_ctrl_en, o_crossbar_en, o_host_if_en}, 3'h1);
    wr(`OFS_MODE_CTRL, 32'h3);
    repeat (100) @(posedge i_ref_clk);
    chk(o_host_if_en, 1'b1);
    rd(`OFS_MODE_CTRL, 32'h0);
    $display("mode test done");
  endtask
  task automatic t_rates;
    int i;
    int pv [7] = '{8, 16, 24, 32, 64, 128, 256};
    logic [5:0] mv [7] = '{6'h08, 6'h00, 6'h20, 6'h10, 6'h00, 6'h00, 6'h00};
    for (i = 0; i < 7; i++)
    begin
      wr(`OFS_CLOCK_EXT, (i > 3) ? i - 3 : 0);
      wr(`OFS_MODE_CTRL, mv[i]);
      repeat (600) @(posedge i_ref_clk);
      chk(per, pv[i]);
    end
    wr(`OFS_CLOCK_EXT, 32'h0);
    wr(`OFS_MODE_CTRL, 32'h0);
    $display("rate test done");
  endtask
  task automatic t_cancel;
    wr(`OFS_CLOCK_EXT, 32'h20);
    wr(`OFS_MODE_CTRL, 32'h3);
    i_irq_pending <= 1'b1;
    repeat (150) @(posedge i_ref_clk);
    chk(o_host_if_en, 1'b1);
    rd(`OFS_MODE_CTRL, 32'h0);
    i_irq_pending <= 1'b0;
    $display("cancel test done");
  endtask
  task automatic t_wake(input logic [5:0] cfg, input int src);
    logic c0;
    i_line_f3 <= (src != 2);
    wr(`OFS_WAKE_CFG, cfg);
    wr(`OFS_CLOCK_EXT, 32'h20);
    wr(`OFS_MODE_CTRL, 32'h13);
    wait_if(1'b0);
    i_irq_pending <= 1'b1;
    i_line_osc_req <= (src == 1);
    repeat (40) @(posedge i_ref_clk);
    chk({o_master_clk, o_int_n, o_host_write_block, o_periph_act_irq_en}, 4'hE);
    c0 = o_crystal_out;
    repeat (4) @(posedge i_ref_clk);
    chk(o_crystal_out !== c0, src == 1 || src == 2);
    i_line_osc_req <= 1'b0;
    if (src == 0) i_hookswitch_input <= ~i_hookswitch_input;
    repeat (20) @(posedge i_ref_clk);
    chk(o_host_if_en, 1'b0);
    if (src != 2) chk(o_crystal_out, 1'b1);
    case (src)
      0: go <= 1'b1;
      1: i_hookswitch_input <= ~i_hookswitch_input;
      2: i_line_f7 <= 1'b1;
      3: i_serial_in_pin <= 1'b0;
      default: i_serial_clk_in <= 1'b1;
    endcase
    @(posedge i_ref_clk);
    go <= 1'b0;
    wait_if(1'b1);
    chk(o_int_n, 1'b1);
    repeat (100) @(posedge i_ref_clk);
    chk(o_int_n, 1'b0);
    chk(per, 32);
    chk(o_serial_clk_oe_n, src != 3);
    chk({o_line_en, o_periph_act_irq_en}, {src == 2, src > 2});
    i_irq_pending <= 1'b0;
    rd(`OFS_MODE_CTRL, 32'h10);
    {i_line_f7, i_serial_in_pin, i_serial_clk_in} <= 3'h2;
    $display("wake test %0d done", src);
  endtask
  task automatic t_rst_wake;
    wr(`OFS_MODE_CTRL, 32'h0B);
    wait_if(1'b0);
    i_reset <= 1'b1;
    repeat (2) @(posedge i_ref_clk);
    i_reset <= 1'b0;
    wait_if(1'b1);
    repeat (100) @(posedge i_ref_clk);
    chk(per, 16);
    rd(`OFS_MODE_CTRL, 32'h0);
    chk(o_serial_frame_sync_oe_n, 1'b1);
    i_crossbar_conn <= 1'b1;
    @(posedge i_ref_clk);
    i_crossbar_conn <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
    chk({o_serial_frame_sync_oe_n, o_serial_clk_oe_n}, 2'h0);
    $display("reset wake test done");
  endtask
  initial
  begin
    {i_psel, i_penable, i_pwrite, i_irq_pending, go, i_line_f7, i_line_osc_req} = 7'h00;
    {i_serial_clk_in, i_crossbar_conn, i_crystal_in, xc, i_paddr, i_pwdata} = '0;
    {i_reset, i_hookswitch_input, i_line_f3, i_serial_in_pin} = 4'hF;
    {fail_count, n_tests, per, clr_n, t0} = '0;
    repeat (16) @(posedge i_ref_clk);
    i_reset <= 1'b0;
    t_reset;
    t_modes;
    t_rates;
    t_cancel;
    t_wake(6'h00, 0);
    t_wake(6'h01, 1);
    t_wake(6'h0A, 2);
    t_wake(6'h34, 3);
    t_wake(6'h14, 4);
    t_rst_wake;
    report_and_stop;
  end
endmodule
`default_nettype wire
